/* File: verilog/ffbb_pkg.sv */
// package for the fiber fault / back-to-back control block
// assumes one 100 MHz clock and an apb master outside
package ffbb_pkg;
  // ===========================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00; // control
  localparam logic [7:0] OFS_STAT   = 8'h04; // live status
  localparam logic [7:0] OFS_IRQ    = 8'h08; // sticky events, w1c
  localparam logic [7:0] OFS_MASK   = 8'h0C; // interrupt mask
  // ===========================================
  // control field positions
  localparam int CTRL_FULL_DUPLEX  = 0;   // fiber duplex select
  localparam int CTRL_FEF_FORCE_OFF = 1;  // software fault send disable
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001; // full duplex default
  // ===========================================
  // event bit positions
  localparam int EV_MODE_CHG  = 0; // copper/fiber change
  localparam int EV_FEF_SET   = 1; // fault raised
  localparam int EV_FEF_CLR   = 2; // fault gone
  localparam int EV_ENERGY    = 3; // copper energy change
  localparam int EV_W         = 4;
  // ===========================================
  // strap codes
  localparam logic [2:0] CFG_MII_B2B  = 3'h6; // binary 110
  localparam logic [2:0] CFG_RMII_B2B = 3'h5; // binary 101
  // ===========================================
  // fault pattern: 84 ones then one zero
  localparam logic [6:0] FEF_ONES     = 7'h54; // 84
  localparam logic [6:0] FEF_PERIOD_M1 = 7'h54; // last index of 85-bit frame
  // ===========================================
  // types
  typedef enum logic [2:0] {
    FFBB_COPPER  = 3'b001,
    FFBB_FX_NOSIG = 3'b010,
    FFBB_FX_SIG  = 3'b100
  } ffbb_mode_t;

  typedef struct packed {
    logic copper;   // level under low band
    logic fx_nosig; // middle band
    logic fx_sig;   // above upper band
  } ffbb_sd_t;

  typedef struct packed {
    logic mii_b2b;
    logic rmii_b2b;
    logic fef_en;
  } ffbb_strap_t;

  typedef struct packed {
    logic fiber;        // fiber mode active
    logic sig_ok;       // fiber signal present
    logic bypass_scr;   // scrambler bypass
    logic bypass_mlt3;  // line code bypass
    logic aneg_en;      // autonegotiation allowed
    logic mdix_auto;    // auto crossover allowed
    logic spd100;       // speed forced 100
    logic adv_10;       // may advertise 10 mb/s
    logic full_duplex;  // duplex choice
  } ffbb_ctl_t;
endpackage : ffbb_pkg

/* File: verilog/ffbb_sd_sync.sv */
// two-flop synchroniser for the three signal-detect bands
// assumes comparator outputs arrive asynchronous to i_clk
`timescale 1ns/100ps
`default_nettype none
module ffbb_sd_sync (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // raw band flags
  input  wire ffbb_pkg::ffbb_sd_t i_sd,
  // synchronised band flags
  output ffbb_pkg::ffbb_sd_t     o_sd
);
  // ===========================================
  // state
  typedef struct packed {
    ffbb_pkg::ffbb_sd_t s1; // first stage, read only by s2
    ffbb_pkg::ffbb_sd_t s2; // second stage
  } ffbb_sync_st_t;
  ffbb_sync_st_t st;
  ffbb_sync_st_t next_st;

  // shift the stages
  always_comb begin
    next_st    = st;
    next_st.s1 = i_sd;
    next_st.s2 = st.s1;
  end

  // register, reset to copper indication
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '{s1: 3'h4, s2: 3'h4};
    end else begin
      st <= next_st;
    end
  end

  assign o_sd = st.s2;
endmodule : ffbb_sd_sync
`default_nettype wire

/* File: verilog/ffbb_fef_gen.sv */
// far-end fault idle pattern serialiser
// assumes i_bit_en pulses once per line bit time
`timescale 1ns/100ps
`default_nettype none
module ffbb_fef_gen (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_active,
  input  wire logic i_bit_en,
  // serial out
  output logic      o_bit,
  output logic      o_valid
);
  // ===========================================
  // state
  typedef struct packed {
    logic [6:0] idx;   // position in the 85-bit frame
    logic       bit_q; // registered line bit
    logic       vld;   // pattern driven
  } ffbb_fef_st_t;
  ffbb_fef_st_t st;
  ffbb_fef_st_t next_st;

  // step through 84 ones then one zero
  always_comb begin
    next_st = st;
    if (!i_active) begin
      next_st.idx = 7'h00; // restart frame on every new fault
      next_st.vld = 1'b0;
      next_st.bit_q = 1'b0;
    end else if (i_bit_en) begin
      next_st.vld   = 1'b1;
      next_st.bit_q = (st.idx < ffbb_pkg::FEF_ONES);
      next_st.idx   = (st.idx == ffbb_pkg::FEF_PERIOD_M1) ? 7'h00 : st.idx + 7'h01;
    end
  end

  // register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_bit   = st.bit_q;
  assign o_valid = st.vld;

  // the zero shows up exactly after 84 ones
  AST_FEF_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_active && i_bit_en && st.idx == ffbb_pkg::FEF_ONES) |=> (o_bit == 1'b0))
    else $error("fault pattern zero missing");
  AST_FEF_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_active && i_bit_en && st.idx < ffbb_pkg::FEF_ONES) |=> (o_bit == 1'b1))
    else $error("fault pattern one missing");
endmodule : ffbb_fef_gen
`default_nettype wire

/* File: verilog/ffbb_ctrl.sv */
// fiber mode select, far-end fault and back-to-back control
// assumes analog comparators give band flags; straps stable at reset release
// Function
// - fiber above 1V, copper below 0.2V
// - middle band: fiber, no signal, fault
// - above upper band: fiber signal present
// - fault sends 84 ones then one zero
// - fault on unless strap low at reset
// - back-to-back copper side refuses 10 Mb/s
// - strap 110 selects mii back-to-back
// - strap 101 selects rmii back-to-back
// - rmii spare rxd2 shows copper energy
// - spare txd2 high silences transmitter; this block does so in rmii back-to-back only
// - fiber bypasses scrambler and line code
// - fiber: no autoneg, no crossover, 100
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module ffbb_ctrl (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // apb slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic [31:0]             o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // fiber signal detect bands
  input  wire ffbb_pkg::ffbb_sd_t i_fiber_sig_detect_in,
  // straps
  input  wire logic [2:0]         i_config_strap,
  input  wire logic               i_fault_disable_strap,
  // copper side
  input  wire logic               i_copper_energy,
  input  wire logic               i_spare_txd2,
  input  wire logic               i_bit_en,
  // control outputs
  output ffbb_pkg::ffbb_ctl_t     o_ctl,
  output ffbb_pkg::ffbb_strap_t   o_strap,
  output logic                    o_far_end_fault,
  output logic                    o_fef_bit,
  output logic                    o_fef_valid,
  output logic                    o_tx_enable,
  output logic                    o_spare_rxd2,
  // interrupt
  output logic                    o_irq
);
  // ===========================================
  // state
  typedef struct packed {
    ffbb_pkg::ffbb_mode_t  mode;     // current band
    ffbb_pkg::ffbb_strap_t strap;    // caught at reset release
    logic                  strap_ok; // straps captured
    logic [31:0]           ctrl;     // control register
    logic [ffbb_pkg::EV_W-1:0] stat; // sticky events
    logic [ffbb_pkg::EV_W-1:0] mask; // interrupt mask
    logic                  energy_q; // previous energy
    logic                  fef;      // fault active
    logic                  rxd2;     // spare rx bit
    logic [31:0]           rdata;    // read data
  } ffbb_st_t;
  ffbb_st_t st;
  ffbb_st_t next_st;

  ffbb_pkg::ffbb_sd_t sd; // synchronised bands

  // ===========================================
  // helpers
  function automatic logic is_fiber(input ffbb_pkg::ffbb_mode_t m);
    is_fiber = (m != ffbb_pkg::FFBB_COPPER);
  endfunction : is_fiber

  // ===========================================
  // submodules
  ffbb_sd_sync u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_sd    (i_fiber_sig_detect_in),
    .o_sd    (sd)
  );

  ffbb_fef_gen u_fef (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_active (st.fef),
    .i_bit_en (i_bit_en),
    .o_bit    (o_fef_bit),
    .o_valid  (o_fef_valid)
  );

  // ===========================================
  // bus decode
  logic acc;  // access phase
  logic wr;   // write strobe
  assign acc = i_psel && i_penable;
  assign wr  = acc && i_pwrite;

  // next state
  always_comb begin
    logic [ffbb_pkg::EV_W-1:0] ev; // events this cycle
    logic                      fef_n;
    ev      = '0;
    fef_n   = 1'b0;
    next_st = st;
    // catch straps one cycle after reset release
    if (!st.strap_ok) begin
      next_st.strap_ok       = 1'b1;
      next_st.strap.mii_b2b  = (i_config_strap == ffbb_pkg::CFG_MII_B2B);
      next_st.strap.rmii_b2b = (i_config_strap == ffbb_pkg::CFG_RMII_B2B);
      next_st.strap.fef_en   = i_fault_disable_strap;
    end
    // band selection; a detect tied high lands in the upper band
    case (1'b1)
      sd.copper:   next_st.mode = ffbb_pkg::FFBB_COPPER;
      sd.fx_nosig: next_st.mode = ffbb_pkg::FFBB_FX_NOSIG;
      sd.fx_sig:   next_st.mode = ffbb_pkg::FFBB_FX_SIG;
      default:     next_st.mode = st.mode;                 // gap between bands
    endcase
    fef_n = (next_st.mode == ffbb_pkg::FFBB_FX_NOSIG) && st.strap.fef_en
            && !st.ctrl[ffbb_pkg::CTRL_FEF_FORCE_OFF];
    next_st.fef      = fef_n;
    next_st.energy_q = i_copper_energy;
    next_st.rxd2     = i_copper_energy;
    ev[ffbb_pkg::EV_MODE_CHG] = is_fiber(next_st.mode) != is_fiber(st.mode);
    ev[ffbb_pkg::EV_FEF_SET]  = fef_n && !st.fef;
    ev[ffbb_pkg::EV_FEF_CLR]  = !fef_n && st.fef;
    ev[ffbb_pkg::EV_ENERGY]   = i_copper_energy != st.energy_q;
    // register writes; sets beat clears
    if (wr) begin
      if (i_paddr == ffbb_pkg::OFS_CTRL) begin
        next_st.ctrl = i_pwdata;
      end else if (i_paddr == ffbb_pkg::OFS_IRQ) begin
        next_st.stat = st.stat & ~i_pwdata[ffbb_pkg::EV_W-1:0];
      end else if (i_paddr == ffbb_pkg::OFS_MASK) begin
        next_st.mask = i_pwdata[ffbb_pkg::EV_W-1:0];
      end
    end
    next_st.stat = next_st.stat | ev;
    // register reads, unmapped read zero
    next_st.rdata = 32'h0000_0000;
    if (i_psel && !i_penable && !i_pwrite) begin
      if (i_paddr == ffbb_pkg::OFS_CTRL) begin
        next_st.rdata = st.ctrl;
      end else if (i_paddr == ffbb_pkg::OFS_STAT) begin
        // bit 3 is spare so the strap field sits at 7:5 and energy at 8
        next_st.rdata = {23'h0, st.rxd2, st.strap, st.fef, 1'b0, st.mode};
      end else if (i_paddr == ffbb_pkg::OFS_IRQ) begin
        next_st.rdata = {28'h0, st.stat};
      end else if (i_paddr == ffbb_pkg::OFS_MASK) begin
        next_st.rdata = {28'h0, st.mask};
      end
    end
  end

  // register state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '{mode: ffbb_pkg::FFBB_COPPER, strap: '0, strap_ok: 1'b0,
              ctrl: ffbb_pkg::CTRL_RESET, stat: '0, mask: '0,
              energy_q: 1'b0, fef: 1'b0, rxd2: 1'b0, rdata: '0};
    end else begin
      st <= next_st;
    end
  end

  // ===========================================
  // outputs
  logic fib; // fiber mode
  assign fib = is_fiber(st.mode);
  always_comb begin
    o_ctl             = '0;
    o_ctl.fiber       = fib;
    o_ctl.sig_ok      = (st.mode == ffbb_pkg::FFBB_FX_SIG);
    o_ctl.bypass_scr  = fib;
    o_ctl.bypass_mlt3 = fib;
    o_ctl.aneg_en     = !fib;
    o_ctl.mdix_auto   = !fib;
    o_ctl.spd100      = fib || st.strap.mii_b2b || st.strap.rmii_b2b;
    o_ctl.adv_10      = !fib && !st.strap.mii_b2b && !st.strap.rmii_b2b;
    o_ctl.full_duplex = st.ctrl[ffbb_pkg::CTRL_FULL_DUPLEX];
  end
  assign o_strap         = st.strap;
  assign o_far_end_fault = st.fef;
  // rmii b2b: spare txd2 high silences the transmitter
  assign o_tx_enable     = !(st.strap.rmii_b2b && i_spare_txd2);
  assign o_spare_rxd2    = st.rxd2 && st.strap.rmii_b2b;
  assign o_irq           = |(st.stat & st.mask);
  assign o_prdata        = st.rdata;
  assign o_pready        = 1'b1; // read data fetched in setup
  assign o_pslverr       = 1'b0;

  // ===========================================
  // checks
  AST_FIBER_BYPASS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_ctl.fiber |-> (o_ctl.bypass_scr && !o_ctl.aneg_en && !o_ctl.mdix_auto && o_ctl.spd100))
    else $error("fiber mode still negotiates");
  AST_COPPER_BAND: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.strap_ok && sd.copper) |=> !o_ctl.fiber)
    else $error("copper band not copper");
  AST_MID_FAULT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sd.fx_nosig && st.strap.fef_en && !st.ctrl[ffbb_pkg::CTRL_FEF_FORCE_OFF] && st.strap_ok)
    |=> (o_far_end_fault && !o_ctl.sig_ok))
    else $error("middle band without fault");
  AST_SIG_OK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sd.fx_sig |=> (o_ctl.sig_ok && o_ctl.fiber && !o_far_end_fault))
    else $error("upper band not signal");
  AST_STRAP_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.strap_ok && !st.strap.fef_en) |-> !o_far_end_fault)
    else $error("fault while strapped off");
  AST_NO_10: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.strap.mii_b2b || st.strap.rmii_b2b) |-> (o_ctl.spd100 && !o_ctl.adv_10))
    else $error("10 mb/s allowed in back-to-back");
  AST_HOLD_GAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (sd == 3'h0) |=> (st.mode == $past(st.mode)))
    else $error("mode moved between bands");
  AST_RXD2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.strap.rmii_b2b && $stable(st.strap)) |=> (o_spare_rxd2 == $past(i_copper_energy)))
    else $error("spare rxd2 not energy");
  AST_TX_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st.strap.rmii_b2b && i_spare_txd2) |-> !o_tx_enable)
    else $error("transmitter not silenced");
  // the release edge itself still resets the state, so only check from the edge that captures
  AST_MII_STRAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rst_n && !st.strap_ok) |=> (st.strap.mii_b2b == ($past(i_config_strap) == ffbb_pkg::CFG_MII_B2B)))
    else $error("mii strap decode wrong");
  AST_RMII_STRAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rst_n && !st.strap_ok) |=> (st.strap.rmii_b2b == ($past(i_config_strap) == ffbb_pkg::CFG_RMII_B2B)))
    else $error("rmii strap decode wrong");
endmodule : ffbb_ctrl
`default_nettype wire

/* File: sim/ffbb_optic.sv */
// far side model: optical module band flags and board inverter
// assumes the bench picks a detect level; purely combinational
`timescale 1ns/100ps
`default_nettype none
module ffbb_optic (
  // level pick: 0 copper, 1 fiber no signal, 2 fiber signal, 3 gap
  input  wire logic [1:0]         i_level,
  // copper energy flag from the device
  input  wire logic               i_spare_rxd2,
  // band flags and transmitter silence line
  output var ffbb_pkg::ffbb_sd_t  o_sd,
  output var logic                o_spare_txd2
);
  // ==========================================
  // band flags
  // between bands no comparator fires at all
  always_comb begin
    o_sd = 3'h0;
    case (i_level)
      2'h0: o_sd.copper = 1'b1;
      2'h1: o_sd.fx_nosig = 1'b1;
      2'h2: o_sd.fx_sig = 1'b1;
      default: o_sd = 3'h0;
    endcase
  end
  // ==========================================
  // board inverter: no energy silences the device transmitter
  // data pins cross straight to the other device; the block carries none of them
  assign o_spare_txd2 = ~i_spare_rxd2;
endmodule : ffbb_optic
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the fiber fault / back-to-back control block
// assumes ffbb_pkg, ffbb_ctrl and ffbb_optic compiled before it
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  // ==========================================
  // stimulus and observed nets
  logic                  i_clk;
  logic                  i_rst_n;
  logic                  i_psel;
  logic                  i_penable;
  logic                  i_pwrite;
  logic [7:0]            i_paddr;
  logic [31:0]           i_pwdata;
  logic [31:0]           o_prdata;
  logic                  o_pready;
  logic                  o_pslverr;
  logic [1:0]            lvl;            // detect level pick
  ffbb_pkg::ffbb_sd_t    sd;             // band flags from far side
  logic [2:0]            i_config_strap;
  logic                  i_fault_disable_strap;
  logic                  i_copper_energy;
  logic                  spare_txd2;
  logic                  i_bit_en;
  ffbb_pkg::ffbb_ctl_t   o_ctl;
  ffbb_pkg::ffbb_strap_t o_strap;
  logic                  o_far_end_fault;
  logic                  o_fef_bit;
  logic                  o_fef_valid;
  logic                  o_tx_enable;
  logic                  o_spare_rxd2;
  logic                  o_irq;
  int                    mismatches;
  int                    n_compared;
  logic [31:0]           rd;
  logic                  err;            // slave error of the last transfer

  ffbb_ctrl uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fiber_sig_detect_in(sd),
    .i_config_strap(i_config_strap), .i_fault_disable_strap(i_fault_disable_strap),
    .i_copper_energy(i_copper_energy), .i_spare_txd2(spare_txd2), .i_bit_en(i_bit_en),
    .o_ctl(o_ctl), .o_strap(o_strap), .o_far_end_fault(o_far_end_fault), .o_fef_bit(o_fef_bit),
    .o_fef_valid(o_fef_valid), .o_tx_enable(o_tx_enable), .o_spare_rxd2(o_spare_rxd2), .o_irq(o_irq));

  ffbb_optic far_side (.i_level(lvl), .i_spare_rxd2(o_spare_rxd2), .o_sd(sd), .o_spare_txd2(spare_txd2));

  // ==========================================
  // clock: 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ==========================================
  // tasks
  // verdict and end of run, shared with the watchdog
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // let n edges pass, then step off the edge so outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  // one apb transfer; ready, read data and error taken at the rising edge that ends it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // read a register and compare it
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rdc

  // reset with given straps, held 3 cycles
  task automatic do_reset(input logic [2:0] cfg, input logic fds);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_config_strap <= cfg;
    i_fault_disable_strap <= fds;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    settle(2);
  endtask : do_reset

  // ==========================================
  // watchdog: tests need under 2000 cycles
  initial begin
    #100000;
    mismatches++;
    $display("wrong value watchdog expected done seen hang");
    report_and_stop();
  end

  // ==========================================
  // main sequence
  // o_ctl order: fiber sig_ok scr mlt3 aneg mdix spd100 adv10 duplex
  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_bit_en, i_copper_energy} = 6'h0;
    {i_paddr, i_pwdata, lvl} = 42'h0;
    {i_config_strap, i_fault_disable_strap} = 4'h0;
    mismatches = 0;
    n_compared = 0;
    // rmii back-to-back, fault on
    do_reset(ffbb_pkg::CFG_RMII_B2B, 1'b1);
    rdc(ffbb_pkg::OFS_CTRL, 32'h0000_0001, "ctrl reset");
    rdc(ffbb_pkg::OFS_STAT, 32'h0000_0061, "stat reset");
    rdc(ffbb_pkg::OFS_IRQ, 32'h0000_0000, "irq reset");
    `CHK("strap rmii", 3'h3, o_strap)
    `CHK("ctl copper", 9'h01D, o_ctl)
    `CHK("tx silenced", 1'b0, o_tx_enable)
    $display("test reset done");
    @(posedge i_clk) lvl <= 2'h1;
    settle(6);
    `CHK("ctl fiber nosig", 9'h165, o_ctl)
    `CHK("fault", 1'b1, o_far_end_fault)
    // no bit pulses so far, so the pattern starts at index 0
    for (int i = 0; i < 170; i++) begin
      @(posedge i_clk) i_bit_en <= 1'b1;
      @(posedge i_clk) i_bit_en <= 1'b0;
      #1 `CHK("fault bit", (i % 85 == 84) ? 1'b0 : 1'b1, o_fef_bit)
    end
    `CHK("fault valid", 1'b1, o_fef_valid)
    @(posedge i_clk) lvl <= 2'h3;
    settle(6);
    rdc(ffbb_pkg::OFS_STAT, 32'h0000_0072, "stat gap hold");
    @(posedge i_clk) lvl <= 2'h2;
    settle(6);
    `CHK("ctl fiber sig", 9'h1E5, o_ctl)
    rdc(ffbb_pkg::OFS_STAT, 32'h0000_0064, "stat fiber sig");
    $display("test bands done");
    rdc(ffbb_pkg::OFS_IRQ, 32'h0000_0007, "irq events");
    `CHK("irq masked", 1'b0, o_irq)
    apb(1'b1, ffbb_pkg::OFS_MASK, 32'h0000_0002);
    settle(2);
    `CHK("irq unmasked", 1'b1, o_irq)
    apb(1'b1, ffbb_pkg::OFS_IRQ, 32'h0000_0002);
    settle(2);
    `CHK("irq cleared", 1'b0, o_irq)
    rdc(ffbb_pkg::OFS_IRQ, 32'h0000_0005, "irq w1c");
    apb(1'b1, ffbb_pkg::OFS_IRQ, 32'h0000_0005);
    rdc(ffbb_pkg::OFS_IRQ, 32'h0000_0000, "irq empty");
    $display("test interrupt done");
    @(posedge i_clk) i_copper_energy <= 1'b1;
    settle(4);
    `CHK("rxd2 energy", 1'b1, o_spare_rxd2)
    `CHK("tx enabled", 1'b1, o_tx_enable)
    rdc(ffbb_pkg::OFS_IRQ, 32'h0000_0008, "irq energy");
    apb(1'b1, ffbb_pkg::OFS_STAT, 32'h0000_0000);
    rdc(ffbb_pkg::OFS_STAT, 32'h0000_0164, "stat read only");
    rdc(8'h10, 32'h0000_0000, "unmapped");
    `CHK("slave error", 1'b0, err)
    apb(1'b1, ffbb_pkg::OFS_CTRL, 32'h0000_0000);
    settle(2);
    `CHK("half duplex", 1'b0, o_ctl.full_duplex)
    apb(1'b1, ffbb_pkg::OFS_CTRL, 32'h0000_0001);
    @(posedge i_clk) lvl <= 2'h0;
    settle(6);
    `CHK("ctl back copper", 9'h01D, o_ctl)
    rdc(ffbb_pkg::OFS_STAT, 32'h0000_0161, "stat copper");
    $display("test energy done");
    // mii back-to-back, fault strapped off
    do_reset(ffbb_pkg::CFG_MII_B2B, 1'b0);
    // copper energy is still present, so the status energy bit is set again after reset
    rdc(ffbb_pkg::OFS_STAT, 32'h0000_0181, "stat mii");
    `CHK("strap mii", 3'h4, o_strap)
    `CHK("rxd2 off in mii", 1'b0, o_spare_rxd2)
    @(posedge i_clk) lvl <= 2'h2;
    settle(6);
    `CHK("ctl tied high", 9'h1E5, o_ctl)
    @(posedge i_clk) lvl <= 2'h1;
    settle(6);
    `CHK("fault strapped off", 1'b0, o_far_end_fault)
    rdc(ffbb_pkg::OFS_STAT, 32'h0000_0182, "stat no fault");
    $display("test straps done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
